// ### core/buck_seq_pkg.sv
// Shared constants and types of the regulator enable and start-up sequencer.
// Assumes a 40 MHz hclk and a single AHB-Lite master with one slave.
package buck_seq_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS   = 25;
    localparam int HICCUP_TIME_US  = 1700;
    localparam int HICCUP_CYCLES   = (HICCUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SS_STEP_TIME_NS = 100;
    localparam int SS_STEP_CYCLES  = (SS_STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SS_STEP_W       = 3;

    // Current limit trip count
    localparam int              LIMIT_W          = 5;
    localparam logic [LIMIT_W-1:0] LIMIT_TRIP_COUNT = 5'h10;

    // Pin positions in the filtered pin vector
    localparam int PIN_COUNT  = 2;
    localparam int PIN_ENABLE = 0;
    localparam int PIN_VOLTAGE_SELECT_PIN   = 1;

    // Register byte addresses
    localparam logic [31:0] ADDR_SETTING_LOW  = 32'h0000_0000;
    localparam logic [31:0] ADDR_SETTING_HIGH = 32'h0000_0004;
    localparam logic [31:0] ADDR_CONTROL      = 32'h0000_0008;
    localparam logic [31:0] ADDR_MONITOR      = 32'h0000_000C;

    // Field positions
    localparam int BIT_ON         = 7;
    localparam int VOLT_MSB       = 6;
    localparam int CTRL_DISCHARGE = 7;
    localparam int CTRL_SLEW_MSB  = 6;
    localparam int CTRL_SLEW_LSB  = 4;
    localparam int CTRL_MODE      = 0;

    // Reset values and monitor codes
    localparam logic [7:0] RST_SETTING_LOW  = 8'hC0;
    localparam logic [7:0] RST_SETTING_HIGH = 8'hC0;
    localparam logic [7:0] RST_CONTROL      = 8'h82;
    localparam logic [7:0] MONITOR_REGULATING = 8'h81;
    localparam logic [7:0] MONITOR_IDLE       = 8'h00;

    // AHB-Lite encodings
    localparam int         HTRANS_ACTIVE_BIT = 1;
    localparam logic [2:0] HSIZE_WORD        = 3'h2;
    localparam logic       HRESP_OKAY        = 1'h0;

    // Sequencer states
    typedef enum logic [3:0] {
        ST_OFF    = 4'h1,
        ST_SOFT   = 4'h2,
        ST_RUN    = 4'h4,
        ST_HICCUP = 4'h8
    } seq_state_type;

endpackage

// ### core/pin_filter.sv
// Three-stage synchroniser and agreement filter for the asynchronous pins.
// Assumes pins may change at any time relative to hclk.
`timescale 1ns/100ps
module pin_filter #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // Pins
    input  wire logic [WIDTH-1:0] pins_async,
    output logic      [WIDTH-1:0] pins_clean
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } filt_state_type;

    filt_state_type r;
    filt_state_type next_r;

    // Only stages two and three are compared; stage one feeds stage two alone
    always_comb begin
        next_r    = r;
        next_r.s1 = pins_async;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.q  = (~(r.s2 ^ r.s3) & r.s2) | ((r.s2 ^ r.s3) & r.q);
    end

    // Pins read as low until filtered, so the regulator stays off at reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign pins_clean = r.q;

endmodule

// ### core/limit_guard.sv
// Consecutive current-limit counter and hiccup wait timer.
// Assumes switch_cycle and limit_hit are hclk-synchronous one-cycle pulses.
`timescale 1ns/100ps
module limit_guard
    import buck_seq_pkg::*;
#(
    parameter int HICCUP_LEN = buck_seq_pkg::HICCUP_CYCLES
) (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Switching events
    input  wire logic switch_cycle,
    input  wire logic limit_hit,
    input  wire logic clear,
    // Results
    output logic      trip,
    output logic      retry
);

    localparam int TW = $clog2(HICCUP_LEN + 1);

    typedef struct packed {
        logic [LIMIT_W-1:0] count;
        logic [TW-1:0]      timer;
        logic               waiting;
        logic               trip;
        logic               retry;
    } guard_state_type;

    guard_state_type r;
    guard_state_type next_r;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Count limit cycles, trip on the sixteenth, then time the off period
    always_comb begin
        next_r       = r;
        next_r.trip  = 1'h0;
        next_r.retry = 1'h0;
        if (clear) begin
            next_r.count   = '0;
            next_r.waiting = 1'h0;
        end else if (switch_cycle && !r.waiting) begin
            if (!limit_hit) begin
                next_r.count = '0;
            end else if (r.count == LIMIT_TRIP_COUNT - 5'h01) begin
                next_r.trip    = 1'h1;
                next_r.count   = '0;
                next_r.waiting = 1'h1;
                next_r.timer   = '0;
            end else begin
                next_r.count = LIMIT_W'(r.count + 5'h01);
            end
        end else if (r.waiting) begin
            if (r.timer == TW'(HICCUP_LEN - 1)) begin
                next_r.waiting = 1'h0;
                next_r.retry   = 1'h1;
            end else begin
                next_r.timer = TW'(r.timer + 1'b1);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign trip  = r.trip;
    assign retry = r.retry;

    property p_trip_on_sixteenth;
        trip |-> $past(r.count) == LIMIT_TRIP_COUNT - 5'h01 && $past(limit_hit);
    endproperty
    a_trip_on_sixteenth: assert property (p_trip_on_sixteenth)
        else $error("trip without sixteen limit cycles");

    property p_retry_after_wait;
        retry |-> $past(r.timer) == TW'(HICCUP_LEN - 1) && !$past(clear);
    endproperty
    a_retry_after_wait: assert property (p_retry_after_wait)
        else $error("retry before full hiccup wait");

    property p_count_clears;
        (clear || (switch_cycle && !limit_hit && !r.waiting)) |=> r.count == '0;
    endproperty
    a_count_clears: assert property (p_count_clears)
        else $error("limit counter not cleared");

endmodule

// ### core/buck_enable_sequencer.sv
// Enable, shutdown, soft-start and hiccup sequencer of a step-down regulator,
// with its setting and control registers on an AHB-Lite slave port.
// Assumes one AHB-Lite master, hresetn as power-on reset, and analog
// switching events synchronous to hclk.
//
// Contract
// - While the enable pin is low the regulator is held fully shut down.
// - Register reads and writes keep working while the enable pin is low.
// - Register contents are kept while enable is low and never reloaded by it.
// - Power-on reset loads every register with its default.
// - With discharge set and enable or the active on-bit low, the discharge load is on.
// - Enable rising while the active on-bit is set starts a soft-start.
// - Soft-start ramps the reference and keeps synchronous rectification off.
// - Sixteen consecutive limit cycles tri-state the output and retry after 1700 us.
// - Both on-bits reset to one so the output starts whatever the select pin says.
// - Select low follows the low on-bit in auto mode, high the high on-bit forced.
// - A control mode bit can disable light-load pulse mode together with the pin.
// - The host reprograms voltage, mode, slew and enable through the serial port.
// - Select low chooses the low setting register, high the high one.
// - While enabled and regulating the monitor register reads 1000 0001.
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module buck_enable_sequencer #(
    parameter int HICCUP_LEN = buck_seq_pkg::HICCUP_CYCLES
) (
    // Clock and power-on reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Pins
    input  wire logic        enable_pin,
    input  wire logic        voltage_select_pin,
    // Analog side
    input  wire logic        supply_ok,
    input  wire logic        switch_cycle,
    input  wire logic        limit_hit,
    // Power stage control
    output logic             regulator_active,
    output logic             soft_start_active,
    output logic             sync_rect_enable,
    output logic             output_tristate,
    output logic             discharge_on,
    output logic             forced_fixed_freq_mode,
    output logic      [6:0]  target_code,
    output logic      [6:0]  reference_code,
    output logic      [2:0]  slew_rate
);
    import buck_seq_pkg::*;

    typedef struct packed {
        logic [7:0]         voltage_setting_low;
        logic [7:0]         voltage_setting_high;
        logic [7:0]         control;
        logic [7:0]         monitor;
        logic               wr_pend;
        logic               rd_wait;
        logic [31:0]        dp_addr;
        logic [31:0]        rdata;
        seq_state_type      state;
        logic [6:0]         ref_code;
        logic [6:0]         target;
        logic [SS_STEP_W-1:0] step_cnt;
        logic               discharge;
        logic               forced;
    } seq_regs_type;

    seq_regs_type r;
    seq_regs_type next_r;

    logic [PIN_COUNT-1:0] pins_clean;
    logic                 pin_en;
    logic                 pin_sel;
    logic                 on_bit;
    logic [6:0]           sel_code;
    logic                 want_on;
    logic                 accept;
    logic                 ss_start;
    logic                 guard_clear;
    logic                 trip;
    logic                 retry;

    // Deglitched pins, four flops each
    pin_filter #(
        .WIDTH      (PIN_COUNT)
    ) u_pins (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .pins_async ({voltage_select_pin, enable_pin}),
        .pins_clean (pins_clean)
    );

    // Current-limit hiccup supervision
    limit_guard #(
        .HICCUP_LEN   (HICCUP_LEN)
    ) u_guard (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .switch_cycle (switch_cycle),
        .limit_hit    (limit_hit),
        .clear        (guard_clear),
        .trip         (trip),
        .retry        (retry)
    );

    // Active setting chosen by the select pin
    assign pin_en   = pins_clean[PIN_ENABLE];
    assign pin_sel  = pins_clean[PIN_VOLTAGE_SELECT_PIN];
    assign on_bit   = pin_sel ? r.voltage_setting_high[BIT_ON]
                              : r.voltage_setting_low[BIT_ON];
    assign sel_code = pin_sel ? r.voltage_setting_high[VOLT_MSB:0]
                              : r.voltage_setting_low[VOLT_MSB:0];
    assign want_on  = pin_en && on_bit && supply_ok;

    // Address phase qualifier; only whole-word transfers are taken
    assign accept = hsel && htrans[HTRANS_ACTIVE_BIT] && hready && (hsize == HSIZE_WORD);

    // Counter is held clear while off and restarted at each soft-start
    assign guard_clear = (r.state == ST_OFF) || ss_start;

    always_comb begin
        next_r    = r;
        ss_start  = 1'h0;

        // Bus: writes land in the data phase, reads take one wait state so
        // that a read right after a write sees the new value
        next_r.wr_pend = 1'h0;
        next_r.rd_wait = 1'h0;
        if (r.wr_pend) begin
            if (r.dp_addr == ADDR_SETTING_LOW) begin
                next_r.voltage_setting_low = hwdata[7:0];
            end else if (r.dp_addr == ADDR_SETTING_HIGH) begin
                next_r.voltage_setting_high = hwdata[7:0];
            end else if (r.dp_addr == ADDR_CONTROL) begin
                next_r.control = hwdata[7:0];
            end
        end
        if (r.rd_wait) begin
            if (r.dp_addr == ADDR_SETTING_LOW) begin
                next_r.rdata = 32'(r.voltage_setting_low);
            end else if (r.dp_addr == ADDR_SETTING_HIGH) begin
                next_r.rdata = 32'(r.voltage_setting_high);
            end else if (r.dp_addr == ADDR_CONTROL) begin
                next_r.rdata = 32'(r.control);
            end else if (r.dp_addr == ADDR_MONITOR) begin
                next_r.rdata = 32'(r.monitor);
            end else begin
                next_r.rdata = '0;
            end
        end
        // Served regardless of the enable pin
        if (accept) begin
            next_r.dp_addr = haddr;
            next_r.wr_pend = hwrite;
            next_r.rd_wait = !hwrite;
        end

        // Sequencer
        next_r.target = sel_code;
        case (r.state)
            ST_OFF: begin
                if (want_on) begin
                    next_r.state    = ST_SOFT;
                    next_r.ref_code = '0;
                    next_r.step_cnt = '0;
                    ss_start        = 1'h1;
                end
            end
            ST_SOFT: begin
                if (trip) begin
                    next_r.state = ST_HICCUP;
                end else if (r.ref_code >= r.target) begin
                    next_r.ref_code = r.target;
                    next_r.state    = ST_RUN;
                end else if (r.step_cnt == SS_STEP_W'(SS_STEP_CYCLES - 1)) begin
                    next_r.step_cnt = '0;
                    next_r.ref_code = 7'(r.ref_code + 7'h01);
                end else begin
                    next_r.step_cnt = SS_STEP_W'(r.step_cnt + 1'b1);
                end
            end
            ST_RUN: begin
                next_r.ref_code = r.target;
                if (trip) begin
                    next_r.state = ST_HICCUP;
                end
            end
            ST_HICCUP: begin
                next_r.ref_code = '0;
                if (retry) begin
                    next_r.state    = ST_SOFT;
                    next_r.step_cnt = '0;
                    ss_start        = 1'h1;
                end
            end
            default: begin
                next_r.state = ST_OFF;
            end
        endcase
        // Shutdown overrides every other state
        if (!want_on) begin
            next_r.state    = ST_OFF;
            next_r.ref_code = '0;
        end

        // Status and power-stage flops
        next_r.monitor   = (r.state == ST_RUN) ? MONITOR_REGULATING
                                               : MONITOR_IDLE;
        next_r.discharge = r.control[CTRL_DISCHARGE] && (!pin_en || !on_bit);
        // Forced mode when select is high, or when the mode bit asks for it
        next_r.forced    = pin_sel || r.control[CTRL_MODE];
    end

    // Power-on defaults; the enable pin never touches these registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r                      <= '0;
            r.voltage_setting_low  <= RST_SETTING_LOW;
            r.voltage_setting_high <= RST_SETTING_HIGH;
            r.control              <= RST_CONTROL;
            r.monitor              <= MONITOR_IDLE;
            r.state                <= ST_OFF;
        end else begin
            r <= next_r;
        end
    end

    // Bus answers; only reads stall
    assign hreadyout = !r.rd_wait;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = r.rdata;

    // Power stage outputs
    assign regulator_active       = (r.state == ST_SOFT) || (r.state == ST_RUN);
    assign soft_start_active      = (r.state == ST_SOFT);
    assign sync_rect_enable       = (r.state == ST_RUN);
    assign output_tristate        = (r.state == ST_OFF) || (r.state == ST_HICCUP);
    assign discharge_on           = r.discharge;
    assign forced_fixed_freq_mode = r.forced;
    assign target_code            = r.target;
    assign reference_code         = r.ref_code;
    assign slew_rate              = r.control[CTRL_SLEW_MSB:CTRL_SLEW_LSB];

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_off_when_disabled;
        !pin_en |=> r.state == ST_OFF && !regulator_active;
    endproperty
    a_off_when_disabled: assert property (p_off_when_disabled)
        else $error("regulator not off with enable low");

    property p_read_one_wait;
        accept && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_one_wait: assert property (p_read_one_wait)
        else $error("read answer timing wrong");

    property p_regs_kept;
        !r.wr_pend |=> $stable(r.voltage_setting_low) && $stable(r.voltage_setting_high)
                       && $stable(r.control);
    endproperty
    a_regs_kept: assert property (p_regs_kept)
        else $error("register changed without a write");

    // Judged on the same sampled pin and on-bit that feed the discharge flop
    property p_discharge;
        r.control[CTRL_DISCHARGE] && (!pin_en || !on_bit) |=> discharge_on;
    endproperty
    a_discharge: assert property (p_discharge)
        else $error("discharge load not on");

    property p_start;
        r.state == ST_OFF && want_on |=> r.state == ST_SOFT && r.ref_code == 7'h00;
    endproperty
    a_start: assert property (p_start)
        else $error("soft-start not begun");

    property p_ramp_done;
        $rose(sync_rect_enable) |-> $past(r.ref_code) >= $past(r.target) && !$past(trip);
    endproperty
    a_ramp_done: assert property (p_ramp_done)
        else $error("rectification before ramp end");

    property p_hiccup_tristate;
        trip && regulator_active && want_on |=> output_tristate && !regulator_active;
    endproperty
    a_hiccup_tristate: assert property (p_hiccup_tristate)
        else $error("output not tri-stated on trip");

    property p_forced_mode;
        pin_sel |=> forced_fixed_freq_mode;
    endproperty
    a_forced_mode: assert property (p_forced_mode)
        else $error("select high without forced mode");

    property p_monitor;
        r.state == ST_RUN |=> r.monitor == MONITOR_REGULATING;
    endproperty
    a_monitor: assert property (p_monitor)
        else $error("monitor not showing regulation");

endmodule

// ### tb/power_stage_model.sv
// Behavioural power stage beside the sequencer: switching events and limit flag.
// Assumes the sequencer samples both outputs on the rising edge of hclk.
`timescale 1ns/100ps
module power_stage_model (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Sequencer side
    input  wire logic regulator_active,
    input  wire logic overload,
    output logic      switch_cycle,
    output logic      limit_hit
);
    logic [1:0] phase;
    logic       fire;

    // One event every four cycles, only while the stage is driven
    assign fire = regulator_active && (phase == 2'h3);

    // Limit flag toggles between events so a stale value is never trusted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase        <= 2'h0;
            switch_cycle <= 1'b0;
            limit_hit    <= 1'b0;
        end else begin
            phase        <= phase + 2'h1;
            switch_cycle <= fire;
            limit_hit    <= fire ? overload : ~limit_hit;
        end
    end
endmodule

// ### tb/tb_top.sv
// Self-checking bench of the enable and start-up sequencer over AHB-Lite.
// Assumes one master, hready looped from hreadyout, a shortened hiccup wait.
`timescale 1ns/100ps
module tb_top;
    import buck_seq_pkg::*;

    localparam int HLEN = 50;
    localparam int LIMIT = 20000;

    logic        hclk, hresetn, hsel, hwrite, hresp, hreadyout;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [1:0]  htrans;
    logic [2:0]  hsize, slew_rate;
    wire logic   hready;
    logic        enable_pin, voltage_select_pin, supply_ok, overload;
    logic        switch_cycle, limit_hit, regulator_active, soft_start_active;
    logic        sync_rect_enable, output_tristate, discharge_on, forced_fixed_freq_mode;
    logic [6:0]  target_code, reference_code;
    int          errors, compares, cycles, n;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    buck_enable_sequencer #(.HICCUP_LEN(HLEN)) buck_enable_sequencer_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .enable_pin(enable_pin), .voltage_select_pin(voltage_select_pin),
        .supply_ok(supply_ok), .switch_cycle(switch_cycle), .limit_hit(limit_hit),
        .regulator_active(regulator_active), .soft_start_active(soft_start_active),
        .sync_rect_enable(sync_rect_enable), .output_tristate(output_tristate),
        .discharge_on(discharge_on), .forced_fixed_freq_mode(forced_fixed_freq_mode),
        .target_code(target_code), .reference_code(reference_code), .slew_rate(slew_rate)
    );

    power_stage_model power_stage_model_inst (
        .hclk(hclk), .hresetn(hresetn), .regulator_active(regulator_active),
        .overload(overload), .switch_cycle(switch_cycle), .limit_hit(limit_hit)
    );

    // Free-running 40 MHz clock
    always #12.5 hclk = ~hclk;

    task automatic print_verdict();
        $display("Compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard, generous against the several hundred cycles expected
    always @(posedge hclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One word transfer; entered just after a rising edge, waits on ready
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] got;
        bus(1'b0, a, 32'h0000_0000, got);
        check(got, exp);
        check(hresp, HRESP_OKAY);
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: pick = regulator_active;
            1: pick = sync_rect_enable;
            2: pick = output_tristate;
            default: pick = soft_start_active;
        endcase
    endfunction

    // Bounded wait for a status level, then compare it
    task automatic wait_chk(input int sel, input int lim, output int cnt);
        cnt = 0;
        while (pick(sel) !== 1'b1 && cnt < lim) begin
            @(posedge hclk);
            cnt++;
        end
        check(pick(sel), 1'b1);
    endtask

    // Counts switching events; the caller starts just after an event edge
    task automatic pulses(input int cnt, input logic lvl);
        overload <= lvl;
        repeat (cnt) begin
            do @(posedge hclk); while (switch_cycle !== 1'b1);
        end
    endtask

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0000_0000;
        enable_pin = 1'b0;
        voltage_select_pin = 1'b0;
        supply_ok = 1'b1;
        overload = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        // Defaults, unmapped read, shutdown with enable low
        rd_chk(ADDR_SETTING_LOW, 32'h0000_00C0);
        rd_chk(ADDR_SETTING_HIGH, 32'h0000_00C0);
        rd_chk(ADDR_CONTROL, 32'h0000_0082);
        rd_chk(ADDR_MONITOR, 32'h0000_0000);
        rd_chk(32'h0000_0010, 32'h0000_0000);
        wr(ADDR_SETTING_LOW, 32'h0000_00A0);
        rd_chk(ADDR_SETTING_LOW, 32'h0000_00A0);
        check(regulator_active, 1'b0);
        check(output_tristate, 1'b1);
        check(discharge_on, 1'b1);
        // Enable rise starts a soft-start, then regulation
        enable_pin <= 1'b1;
        wait_chk(0, 20, n);
        check(sync_rect_enable, 1'b0);
        wait_chk(1, 1000, n);
        check(target_code, 7'h20);
        check(reference_code, 7'h20);
        check(forced_fixed_freq_mode, 1'b0);
        check(discharge_on, 1'b0);
        rd_chk(ADDR_MONITOR, 32'h0000_0081);
        // One-cycle glitch on enable must be dropped
        enable_pin <= 1'b0;
        @(posedge hclk);
        enable_pin <= 1'b1;
        repeat (10) @(posedge hclk);
        check(sync_rect_enable, 1'b1);
        // Mode bit and slew field
        wr(ADDR_CONTROL, 32'h0000_00D1);
        repeat (4) @(posedge hclk);
        check(forced_fixed_freq_mode, 1'b1);
        check(slew_rate, 3'h5);
        wr(ADDR_CONTROL, 32'h0000_0080);
        repeat (4) @(posedge hclk);
        check(forced_fixed_freq_mode, 1'b0);
        // Select high follows the high setting in forced mode
        wr(ADDR_SETTING_HIGH, 32'h0000_0085);
        voltage_select_pin <= 1'b1;
        repeat (10) @(posedge hclk);
        check(forced_fixed_freq_mode, 1'b1);
        check(target_code, 7'h05);
        wr(ADDR_SETTING_HIGH, 32'h0000_0005);
        repeat (6) @(posedge hclk);
        check(regulator_active, 1'b0);
        check(discharge_on, 1'b1);
        rd_chk(ADDR_MONITOR, 32'h0000_0000);
        voltage_select_pin <= 1'b0;
        wait_chk(1, 1000, n);
        // Limit counter clears on a clean cycle; sixteen in a row trip
        pulses(1, 1'b0);
        pulses(15, 1'b1);
        pulses(1, 1'b0);
        pulses(15, 1'b1);
        pulses(1, 1'b0);
        check(output_tristate, 1'b0);
        pulses(16, 1'b1);
        overload <= 1'b0;
        wait_chk(2, 6, n);
        check(regulator_active, 1'b0);
        wait_chk(3, HLEN + 20, n);
        check(32'(n >= HLEN && n <= HLEN + 4), 32'h1);
        check(sync_rect_enable, 1'b0);
        wait_chk(1, 1000, n);
        // Supply below lockout forces off, bus still served
        supply_ok <= 1'b0;
        repeat (3) @(posedge hclk);
        check(regulator_active, 1'b0);
        rd_chk(ADDR_CONTROL, 32'h0000_0080);
        supply_ok <= 1'b1;
        // Enable low shuts down and keeps every register
        enable_pin <= 1'b0;
        repeat (10) @(posedge hclk);
        check(output_tristate, 1'b1);
        check(discharge_on, 1'b1);
        rd_chk(ADDR_SETTING_LOW, 32'h0000_00A0);
        rd_chk(ADDR_SETTING_HIGH, 32'h0000_0005);
        rd_chk(ADDR_CONTROL, 32'h0000_0080);
        // Second power-on reset reloads defaults
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(ADDR_SETTING_LOW, 32'h0000_00C0);
        rd_chk(ADDR_CONTROL, 32'h0000_0082);
        print_verdict();
    end
endmodule
